// >>> design/tdr_defines.svh
`ifndef TDR_DEFINES_SVH
`define TDR_DEFINES_SVH

`define TDR_ADDR_W 4
`define TDR_ADDR_SENSING_MODE_OPTIONS 4'h0
`define TDR_ADDR_ACQUISITION_TIMING_OPTIONS 4'h1
`define TDR_ADDR_STATUS 4'h2
`define TDR_ADDR_IRQ_STAT 4'h3
`define TDR_ADDR_IRQ_CLR 4'h4
`define TDR_ADDR_IRQ_EN 4'h5
`define TDR_ADDR_REF 4'h6
`define TDR_ADDR_SIG 4'h7

`define TDR_SENSING_MODE_OPTIONS_RST 8'h00
`define TDR_ACQUISITION_TIMING_OPTIONS_RST 8'h00
`define TDR_ACQUISITION_TIMING_OPTIONS_WMASK 8'h06

`define TDR_PWR_MSB 7
`define TDR_PWR_LSB 6
`define TDR_THR_MSB 5
`define TDR_THR_LSB 4
`define TDR_FRZ_MSB 3
`define TDR_FRZ_LSB 2
`define TDR_OUT_MSB 1
`define TDR_OUT_LSB 0
`define TDR_SMP_BIT 2
`define TDR_CHG_BIT 1

`define TDR_CLK_HZ 20000000
`define TDR_SMP_SLOW_MS 20
`define TDR_SMP_FAST_MS 10
`define TDR_CHG_SLOW_KHZ 125
`define TDR_CHG_FAST_KHZ 250
`define TDR_FRZ_SHORT_S 15
`define TDR_FRZ_LONG_S 45
`define TDR_CAL_SAMPLES 32
`define TDR_CAL_SHIFT 5

`define TDR_IRQ_DET_ON 0
`define TDR_IRQ_DET_OFF 1
`define TDR_IRQ_FRZ_TO 2
`define TDR_IRQ_CAL 3

`endif

// >>> design/tdr_pkg.sv
package tdr_pkg;
	typedef enum logic [1:0] {TDR_PWR_LP_ZOOM, TDR_PWR_NORMAL, TDR_PWR_XLP_ZOOM, TDR_PWR_XLP}
		tdr_pwr_t;
	typedef enum logic [1:0] {TDR_THR_STD_PROX, TDR_THR_STD_TOUCH, TDR_THR_SENS_PROX,
		TDR_THR_SENS_TOUCH} tdr_thr_t;
	typedef enum logic [1:0] {TDR_FRZ_15S, TDR_FRZ_45S, TDR_FRZ_RSVD, TDR_FRZ_INF} tdr_frz_t;
	typedef enum logic [1:0] {TDR_OUT_ACTIVE, TDR_OUT_TOGGLE, TDR_OUT_LATCH3, TDR_OUT_LATCH30}
		tdr_out_t;
	typedef enum {TDR_ST_CAL, TDR_ST_RUN} tdr_state_t;
endpackage : tdr_pkg

// >>> design/tdr_core.sv
`timescale 1ns/1ps
`include "tdr_defines.svh"

// Contract
// - stop reference tracking the moment a detection begins
// - end the freeze once detection lasts the programmed timeout
// - after timeout, tracking resumes and reference follows the signal
// - report no detection once difference falls below threshold
// - no new touch until reference minus threshold crosses signal again
// - entry and exit each need their own run of consecutive samples
// - detection shows as high, no detection as low
// - option bits reset to zero and zero encodings set behaviour
// - sampling bit: clear selects 20 ms, set selects 10 ms
// - transfer bit: clear selects 125 kHz, set selects 250 kHz
// - power field: 00 lp zoom, 01 normal, 10 xlp zoom, 11 xlp
// - threshold field: 00 std prox, 01 std touch, 10 sens prox, 11 sens touch
// - freeze field: 00 15 s, 01 45 s, 10 reserved, 11 infinite
// - output field: 00 active, 01 toggle, 10 3 s latch, 11 30 s latch; the code drives both latch codes as active
// - initial reference is mean of 32 bursts, normal rate meanwhile
// - detect when signal is below reference by at least threshold
module tdr_core import tdr_pkg::*; #(
	parameter int CW = 16,
	parameter int DDC = 3,
	parameter int RELEASE_DEBOUNCE_COUNT = 3,
	parameter logic [15:0] THR_STD_PROX = 16'h0014,
	parameter logic [15:0] THR_STD_TOUCH = 16'h0028,
	parameter logic [15:0] THR_SENS_PROX = 16'h000a,
	parameter logic [15:0] THR_SENS_TOUCH = 16'h001e,
	parameter int FILT_SHIFT = 4,
	parameter longint FRZ_SHORT_CYC = longint'(`TDR_FRZ_SHORT_S) * `TDR_CLK_HZ,
	parameter longint FRZ_LONG_CYC = longint'(`TDR_FRZ_LONG_S) * `TDR_CLK_HZ
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [`TDR_ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic [CW-1:0] burst_count,
	input wire logic burst_valid,
	output logic detect_out,
	output logic sample_fast,
	output logic charge_fast,
	output logic burst_normal_rate,
	output logic irq
);
	localparam int TW = 40;
	localparam logic [TW-1:0] FRZ_S = TW'(FRZ_SHORT_CYC);
	localparam logic [TW-1:0] FRZ_L = TW'(FRZ_LONG_CYC);

	function automatic logic [15:0] thr_sel(input tdr_thr_t t);
		unique case (t)
			TDR_THR_STD_PROX: thr_sel = THR_STD_PROX;
			TDR_THR_STD_TOUCH: thr_sel = THR_STD_TOUCH;
			TDR_THR_SENS_PROX: thr_sel = THR_SENS_PROX;
			TDR_THR_SENS_TOUCH: thr_sel = THR_SENS_TOUCH;
		endcase
	endfunction : thr_sel

	logic [7:0] sensing_mode_options_reg;
	logic [7:0] acquisition_timing_options_reg;
	logic [3:0] irq_stat_reg;
	logic [3:0] irq_en_reg;
	logic [CW+`TDR_CAL_SHIFT-1:0] acc_reg;
	logic [5:0] cal_cnt_reg;
	tdr_state_t state_reg;
	logic [CW+FILT_SHIFT-1:0] ref_reg;
	logic [CW-1:0] sig_reg;
	logic raw_q1_reg;
	logic raw_q2_reg;
	logic valid_q1_reg;
	logic valid_q2_reg;
	logic valid_q3_reg;
	logic [7:0] run_reg;
	logic det_reg;
	logic frz_reg;
	logic [TW-1:0] frz_cnt_reg;
	logic out_reg;
	logic [CW-1:0] cnt_q1_reg;
	logic [CW-1:0] cnt_q2_reg;

	wire tdr_pwr_t pwr = tdr_pwr_t'(sensing_mode_options_reg[`TDR_PWR_MSB:`TDR_PWR_LSB]);
	wire tdr_thr_t thr_mode = tdr_thr_t'(sensing_mode_options_reg[`TDR_THR_MSB:`TDR_THR_LSB]);
	wire tdr_frz_t frz_mode = tdr_frz_t'(sensing_mode_options_reg[`TDR_FRZ_MSB:`TDR_FRZ_LSB]);
	wire tdr_out_t out_mode = tdr_out_t'(sensing_mode_options_reg[`TDR_OUT_MSB:`TDR_OUT_LSB]);
	wire [CW-1:0] ref_val = ref_reg[CW+FILT_SHIFT-1:FILT_SHIFT];
	wire [15:0] thr = thr_sel(thr_mode);
	wire [CW:0] ref_minus_thr = {1'b0, ref_val} - {{(CW+1-16){1'b0}}, thr};
	// below reference by at least threshold, reference minus threshold crossed
	wire raw_det = !ref_minus_thr[CW] && ({1'b0, cnt_q2_reg} <= ref_minus_thr);
	wire sample_new = valid_q2_reg && !valid_q3_reg;
	wire calibrating = (state_reg == TDR_ST_CAL);
	// no step on the edge that declares the detection either
	wire tracking = !frz_reg && !det_run_done;
	wire [TW-1:0] frz_limit = (frz_mode == TDR_FRZ_45S) ? FRZ_L : FRZ_S;
	wire frz_inf = (frz_mode == TDR_FRZ_INF) || (frz_mode == TDR_FRZ_RSVD);
	wire frz_expire = det_reg && frz_reg && !frz_inf && (frz_cnt_reg >= frz_limit - 1'b1);
	wire det_run_done = sample_new && !det_reg && raw_q2_reg && (run_reg >= 8'(DDC - 1));
	wire rel_run_done = sample_new && det_reg && !raw_q2_reg && (run_reg >= 8'(RELEASE_DEBOUNCE_COUNT - 1));
	wire [CW+FILT_SHIFT:0] ref_ext = {1'b0, ref_reg};
	wire [CW+FILT_SHIFT:0] ref_step = (ref_ext - {{FILT_SHIFT{1'b0}}, ref_val})
		+ {{FILT_SHIFT+1{1'b0}}, cnt_q2_reg};
	wire [CW+FILT_SHIFT-1:0] ref_next = ref_step[CW+FILT_SHIFT-1:0];
	wire [3:0] irq_ev = {sample_new && calibrating && (cal_cnt_reg == 6'(`TDR_CAL_SAMPLES - 1)),
		frz_expire, rel_run_done, det_run_done};
	wire [3:0] irq_stat_next = (irq_stat_reg & ~((wr && addr == `TDR_ADDR_IRQ_CLR) ?
		wdata[3:0] : 4'h0)) | irq_ev;
	wire [15:0] rdata_next = (addr == `TDR_ADDR_SENSING_MODE_OPTIONS) ? {8'h00, sensing_mode_options_reg} :
		(addr == `TDR_ADDR_ACQUISITION_TIMING_OPTIONS) ? {8'h00, acquisition_timing_options_reg} :
		(addr == `TDR_ADDR_STATUS) ? {11'h000, frz_reg, calibrating, out_reg, raw_q2_reg, det_reg} :
		(addr == `TDR_ADDR_IRQ_STAT) ? {12'h000, irq_stat_reg} :
		(addr == `TDR_ADDR_IRQ_EN) ? {12'h000, irq_en_reg} :
		(addr == `TDR_ADDR_REF) ? 16'(ref_val) :
		(addr == `TDR_ADDR_SIG) ? 16'(sig_reg) : 16'h0000;
	wire [CW+`TDR_CAL_SHIFT-1:0] acc_next = acc_reg + (CW+`TDR_CAL_SHIFT)'(cnt_q2_reg);

	// option bytes, reset to the blank all-zero state
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sensing_mode_options_reg <= `TDR_SENSING_MODE_OPTIONS_RST;
			acquisition_timing_options_reg <= `TDR_ACQUISITION_TIMING_OPTIONS_RST;
			irq_en_reg <= 4'h0;
			irq_stat_reg <= 4'h0;
			rdata <= 16'h0000;
		end else if (ce) begin
			if (wr && addr == `TDR_ADDR_SENSING_MODE_OPTIONS)
				sensing_mode_options_reg <= wdata;
			if (wr && addr == `TDR_ADDR_ACQUISITION_TIMING_OPTIONS)
				acquisition_timing_options_reg <= wdata & `TDR_ACQUISITION_TIMING_OPTIONS_WMASK;
			if (wr && addr == `TDR_ADDR_IRQ_EN)
				irq_en_reg <= wdata[3:0];
			irq_stat_reg <= irq_stat_next;
			if (rd)
				rdata <= rdata_next;
		end
	end

	// front-end inputs cross from the acquisition domain
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			valid_q1_reg <= 1'b0;
			valid_q2_reg <= 1'b0;
			valid_q3_reg <= 1'b0;
			cnt_q1_reg <= '0;
			cnt_q2_reg <= '0;
		end else if (ce) begin
			valid_q1_reg <= burst_valid;
			valid_q2_reg <= valid_q1_reg;
			valid_q3_reg <= valid_q2_reg;
			cnt_q1_reg <= burst_count;
			cnt_q2_reg <= cnt_q1_reg;
		end
	end

	// calibration and reference tracking
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg <= TDR_ST_CAL;
			cal_cnt_reg <= 6'h00;
			acc_reg <= '0;
			ref_reg <= '0;
			sig_reg <= '0;
		end else if (ce && sample_new) begin
			sig_reg <= cnt_q2_reg;
			unique case (state_reg)
				TDR_ST_CAL: begin
					acc_reg <= acc_next;
					cal_cnt_reg <= cal_cnt_reg + 6'h01;
					if (cal_cnt_reg == 6'(`TDR_CAL_SAMPLES - 1)) begin
						ref_reg <= {acc_next[CW+`TDR_CAL_SHIFT-1:`TDR_CAL_SHIFT],
							{FILT_SHIFT{1'b0}}};
						state_reg <= TDR_ST_RUN;
					end
				end
				TDR_ST_RUN: begin
					if (tracking)
						ref_reg <= ref_next;
				end
			endcase
		end
	end

	// raw decision registers on every enabled clock; the debounce run counts once per sample
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			raw_q1_reg <= 1'b0;
			raw_q2_reg <= 1'b0;
			run_reg <= 8'h00;
			det_reg <= 1'b0;
		end else if (ce) begin
			raw_q1_reg <= raw_det && !calibrating;
			raw_q2_reg <= raw_q1_reg;
			if (sample_new) begin
				if (det_run_done) begin
					det_reg <= 1'b1;
					run_reg <= 8'h00;
				end else if (rel_run_done) begin
					det_reg <= 1'b0;
					run_reg <= 8'h00;
				end else if (raw_q2_reg != det_reg)
					run_reg <= run_reg + 8'h01;
				else
					run_reg <= 8'h00;
			end
		end
	end

	// freeze control and timeout counter
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			frz_reg <= 1'b0;
			frz_cnt_reg <= '0;
		end else if (ce) begin
			if (det_run_done) begin
				frz_reg <= 1'b1;
				frz_cnt_reg <= '0;
			end else if (!det_reg) begin
				frz_reg <= 1'b0;
				frz_cnt_reg <= '0;
			end else if (frz_expire) begin
				frz_reg <= 1'b0;
			end else if (frz_reg) begin
				frz_cnt_reg <= frz_cnt_reg + 1'b1;
			end
		end
	end

	// output pin and mode strobes; latch modes behave as active
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			out_reg <= 1'b0;
			detect_out <= 1'b0;
			sample_fast <= 1'b0;
			charge_fast <= 1'b0;
			burst_normal_rate <= 1'b1;
			irq <= 1'b0;
		end else if (ce) begin
			if (out_mode == TDR_OUT_TOGGLE) begin
				if (det_run_done)
					out_reg <= !out_reg;
			end else
				out_reg <= det_reg;
			detect_out <= out_reg;
			sample_fast <= acquisition_timing_options_reg[`TDR_SMP_BIT];
			charge_fast <= acquisition_timing_options_reg[`TDR_CHG_BIT];
			burst_normal_rate <= calibrating || (pwr == TDR_PWR_NORMAL) ||
				(det_reg && pwr != TDR_PWR_XLP);
			irq <= |(irq_stat_reg & irq_en_reg);
		end
	end

endmodule : tdr_core

// >>> verification/tdr_front_end.sv
`timescale 1ns/1ps
module tdr_front_end (
	input wire logic mclk,
	input wire logic rst,
	input wire logic run,
	input wire logic [15:0] level,
	output logic [15:0] burst_count,
	output logic burst_valid
);
	logic [3:0] phase_reg;
	logic [15:0] held_reg;
	logic run_reg;
	wire live = phase_reg >= 4'h2 && phase_reg < 4'hf;
	// count only meaningful around the strobe, scrambled otherwise
	assign burst_count = live ? held_reg : ~held_reg;
	assign burst_valid = run_reg && phase_reg >= 4'h4 && phase_reg < 4'hc;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			{phase_reg, held_reg, run_reg} <= '0;
		end else begin
			phase_reg <= phase_reg + 4'h1;
			if (phase_reg == 4'h0) {run_reg, held_reg} <= {run, level};
		end
	end
endmodule : tdr_front_end

// >>> verification/tdr_core_properties.sv
`timescale 1ns/1ps
`include "tdr_defines.svh"
module tdr_core_properties #(
	parameter int DDC = 3
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [`TDR_ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic burst_valid,
	input wire logic detect_out,
	input wire logic sample_fast,
	input wire logic charge_fast,
	input wire logic burst_normal_rate,
	input wire logic irq
);
	logic [5:0] cal_cnt;
	logic [3:0] since_cnt;
	logic det_q, bv_q;
	wire rise = burst_valid && !bv_q;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			{cal_cnt, since_cnt, det_q, bv_q} <= '0;
		end else begin
			bv_q <= burst_valid;
			det_q <= detect_out;
			if (rise && cal_cnt != 6'h3f) cal_cnt <= cal_cnt + 6'h1;
			if (detect_out != det_q) since_cnt <= 4'h0;
			else if (rise && since_cnt != 4'hf) since_cnt <= since_cnt + 4'h1;
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	a_rdata_holds: assert property (!($past(rd) && $past(ce)) |-> rdata == $past(rdata))
		else $error("rdata changed without a read");
	a_unmapped_zero: assert property (rd && ce && addr[3] |=> rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_sample_map: assert property (wr && ce && addr == `TDR_ADDR_ACQUISITION_TIMING_OPTIONS |->
		##2 sample_fast == $past(wdata[`TDR_SMP_BIT], 2)) else $error("sample_fast wrong");
	a_charge_map: assert property (wr && ce && addr == `TDR_ADDR_ACQUISITION_TIMING_OPTIONS |->
		##2 charge_fast == $past(wdata[`TDR_CHG_BIT], 2)) else $error("charge_fast wrong");
	a_irq_masked: assert property (wr && ce && addr == `TDR_ADDR_IRQ_EN && wdata == 8'h00
		|-> ##2 !irq) else $error("irq high while masked");
	a_cal_rate: assert property (cal_cnt < 32 |-> burst_normal_rate && !detect_out)
		else $error("calibration rate or output wrong");
	a_debounce_run: assert property ($changed(detect_out) |-> since_cnt >= DDC - 1)
		else $error("output changed without sample run");
	a_reset_quiet: assert property ($past(rst) |-> !detect_out && !irq && !sample_fast
		&& !charge_fast && burst_normal_rate) else $error("reset outputs wrong");
	c_det_on: cover property ($rose(detect_out));
	c_det_off: cover property ($fell(detect_out));
	c_irq: cover property ($rose(irq));
endmodule : tdr_core_properties
bind tdr_core tdr_core_properties #(.DDC(DDC)) u_props (.mclk, .rst, .ce, .addr, .wdata, .wr,
	.rd, .rdata, .burst_valid, .detect_out, .sample_fast, .charge_fast, .burst_normal_rate, .irq);

// >>> verification/tb_tdr_core.sv
`timescale 1ns/1ps
module tb_tdr_core;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic run = 1'b0;
	logic ce = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic [15:0] level = 16'h03e8;
	logic [15:0] rdata, burst_count, rv, frozen;
	logic burst_valid, detect_out, sample_fast, charge_fast, burst_normal_rate, irq;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	always #25 mclk = ~mclk;
	tdr_front_end u_fe (.mclk, .rst, .run, .level, .burst_count, .burst_valid);
	tdr_core #(.FRZ_SHORT_CYC(1500), .FRZ_LONG_CYC(4500)) u_dut (.mclk, .rst, .ce,
		.addr, .wdata, .wr, .rd, .rdata, .burst_count, .burst_valid, .detect_out,
		.sample_fast, .charge_fast, .burst_normal_rate, .irq);
	task automatic check(input string w, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", w, exp, seen);
		end
	endtask : check
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		{wr, addr, wdata} <= {1'b1, a, d};
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [3:0] a);
		@(posedge mclk);
		{rd, addr} <= {1'b1, a};
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		rv = rdata;
	endtask : rreg
	task automatic rchk(input string w, input logic [3:0] a, input logic [15:0] e);
		rreg(a);
		check(w, rv, e);
	endtask : rchk
	task automatic spin(input int n);
		repeat (n) @(negedge mclk);
	endtask : spin
	task automatic wait_det(input logic v, input int n);
		for (int i = 0; i < n && detect_out !== v; i++) @(negedge mclk);
	endtask : wait_det
	task automatic close_out();
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		spin(1);
		check("det", detect_out, 16'h0000);
		check("rate", burst_normal_rate, 16'h0001);
		rchk("sensing_mode_options", 4'h0, 16'h0000);
		rchk("acquisition_timing_options", 4'h1, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			wreg(4'h0, {4{i[1:0]}});
			rchk("sensing_mode_options", 4'h0, {8'h00, {4{i[1:0]}}});
		end
		// writes with the clock enable low must leave the options alone
		@(posedge mclk);
		ce <= 1'b0;
		wreg(4'h0, 8'h5a);
		@(posedge mclk);
		ce <= 1'b1;
		rchk("frozen", 4'h0, 16'h00ff);
		wreg(4'h1, 8'h04);
		rchk("acquisition_timing_options", 4'h1, 16'h0004);
		check("smp", {14'h0000, sample_fast, charge_fast}, 16'h0002);
		wreg(4'h1, 8'hfb);
		rchk("acquisition_timing_options", 4'h1, 16'h0002);
		check("chg", {14'h0000, sample_fast, charge_fast}, 16'h0001);
		rchk("none", 4'hf, 16'h0000);
		wreg(4'h0, 8'h00);
		wreg(4'h5, 8'h0f);
		@(posedge mclk);
		run <= 1'b1;
		spin(36 * 16);
		rchk("ref", 4'h6, 16'h03e8);
		check("rate", burst_normal_rate, 16'h0000);
		check("irq", irq, 16'h0001);
		rchk("stat", 4'h3, 16'h0008);
		wreg(4'h4, 8'h0f);
		rchk("stat", 4'h3, 16'h0000);
		check("irq", irq, 16'h0000);
		// 30 below the reference, standard proximity, 15 s freeze, active output
		@(posedge mclk);
		level <= 16'h03ca;
		spin(16);
		check("det", detect_out, 16'h0000);
		wait_det(1'b1, 8 * 16);
		check("det", detect_out, 16'h0001);
		check("rate", burst_normal_rate, 16'h0001);
		// two filter steps of 1/16 toward 970 during the entry run, then frozen
		rchk("ref", 4'h6, 16'h03e4);
		spin(40 * 16);
		rchk("ref", 4'h6, 16'h03e4);
		check("det", detect_out, 16'h0001);
		wait_det(1'b0, 120 * 16);
		check("det", detect_out, 16'h0000);
		rreg(4'h6);
		check("moved", {15'h0000, rv < 16'h03e4}, 16'h0001);
		rchk("stat", 4'h3, 16'h0007);
		check("irq", irq, 16'h0001);
		spin(20 * 16);
		check("masked", detect_out, 16'h0000);
		// sensitive proximity, 45 s freeze, extreme low power
		wreg(4'h4, 8'h0f);
		wreg(4'h0, 8'he4);
		rreg(4'h6);
		@(posedge mclk);
		level <= rv - 16'h000f;
		wait_det(1'b1, 8 * 16);
		check("det", detect_out, 16'h0001);
		check("rate", burst_normal_rate, 16'h0000);
		rreg(4'h6);
		frozen = rv;
		spin(100 * 16);
		rchk("ref", 4'h6, frozen);
		check("det", detect_out, 16'h0001);
		wait_det(1'b0, 240 * 16);
		check("det", detect_out, 16'h0000);
		// standard touch, infinite freeze, normal power, toggle output
		wreg(4'h0, 8'h5d);
		spin(2);
		check("rate", burst_normal_rate, 16'h0001);
		rreg(4'h6);
		@(posedge mclk);
		level <= rv - 16'h001e;
		spin(8 * 16);
		check("det", detect_out, 16'h0000);
		rreg(4'h6);
		@(posedge mclk);
		level <= rv - 16'h0046;
		wait_det(1'b1, 8 * 16);
		check("det", detect_out, 16'h0001);
		rreg(4'h6);
		frozen = rv;
		spin(300 * 16);
		rchk("ref", 4'h6, frozen);
		check("det", detect_out, 16'h0001);
		@(posedge mclk);
		level <= frozen;
		spin(8 * 16);
		check("det", detect_out, 16'h0001);
		rchk("status", 4'h2, 16'h0004);
		@(posedge mclk);
		level <= frozen - 16'h0046;
		wait_det(1'b0, 8 * 16);
		check("det", detect_out, 16'h0000);
		check("irq", irq, 16'h0001);
		wreg(4'h5, 8'h00);
		spin(2);
		check("irq", irq, 16'h0000);
		close_out();
	end
endmodule : tb_tdr_core
